// >>> scd_pkg.sv
// Constants and types for the pass-through and bus reset command decoder
package scd_pkg;

  // ==========================================================
  // Parameter block word offsets
  localparam logic [4:0] W_CMD = 5'h00;
  localparam logic [4:0] W_OPT = 5'h01;
  localparam logic [4:0] W_STAT = 5'h02;
  localparam logic [4:0] W_VEC = 5'h04;
  localparam logic [4:0] W_LVL = 5'h05;
  localparam logic [4:0] W_VTT = 5'h07;
  localparam logic [4:0] W_ADDR_HI = 5'h08;
  localparam logic [4:0] W_ADDR_LO = 5'h09;
  localparam logic [4:0] W_LEN_HI = 5'h0a;
  localparam logic [4:0] W_LEN_LO = 5'h0b;
  localparam logic [4:0] W_SG_HI = 5'h0c;
  localparam logic [4:0] W_SG_LO = 5'h0d;
  localparam logic [4:0] W_BUS = 5'h0e;
  localparam logic [4:0] W_UNIT = 5'h0f;
  localparam logic [4:0] W_CDB = 5'h10;
  localparam logic [4:0] W_LAST = 5'h1f;
  localparam logic [4:0] FETCH_END = 5'h11;

  // ==========================================================
  // Command codes and field positions
  localparam logic [15:0] CMD_PASS = 16'h0020;
  localparam logic [15:0] CMD_RESET = 16'h0022;
  localparam int OPT_IRQ_BIT = 0;
  localparam int OPT_SG_BIT = 1;
  localparam int OPT_DIR_BIT = 8;
  localparam int UNIT_BUS_BIT = 6;
  localparam int UNIT_EXT_BIT = 7;
  localparam int RST_BUS_BIT = 15;
  localparam logic [1:0] MT_SHORT_IO = 2'h3;

  // ==========================================================
  // Return status values
  localparam logic [15:0] STAT_RESET_OK = 16'h0011;
  localparam logic [7:0] ERR_BAD_CMD = 8'h01;
  localparam logic [7:0] ERR_BAD_GROUP = 8'h02;
  localparam logic [7:0] ERR_BAD_LEN = 8'h03;
  localparam logic [7:0] SCSI_CHECK = 8'h02;

  // ==========================================================
  // Descriptor sizing
  localparam logic [5:0] CDB_LEN_G0 = 6'h06;
  localparam logic [5:0] CDB_LEN_G12 = 6'h0a;
  localparam logic [5:0] CDB_LEN_G5 = 6'h0c;
  localparam logic [7:0] BLOCK_OVERHEAD = 8'h10;
  localparam logic [7:0] BLOCK_MAX_WORDS = 8'h20;

  // Short I/O base for lists held on board; value is arbitrary
  localparam logic [31:0] SIO_BASE = 32'h0000_0000;

  // ==========================================================
  // Error policy per queue
  typedef enum logic [1:0] {
    POL_NONE,
    POL_FREEZE,
    POL_ABORT,
    POL_SENSE
  } scd_policy_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DECODE,
    ST_CDB_RD,
    ST_CDB_LD,
    ST_CDB_TX,
    ST_WAIT,
    ST_SENSE,
    ST_RST_GO,
    ST_RST_WAIT,
    ST_WB_STAT,
    ST_WB_LEN_HI,
    ST_WB_LEN_LO,
    ST_FINISH
  } scd_state_t;

endpackage

// >>> scd_block_ram.sv
// Parameter block storage: 32 words of 16 bits, registered read
`timescale 1ns/10ps
`default_nettype none

module scd_block_ram (
  // Clock
  input wire logic clk,
  // Access port
  input wire logic [4:0] addr,
  input wire logic we,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  logic [15:0] mem [0:31];

  // No reset on the array; host must fill the block before use
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

`default_nettype wire

// >>> scd_core.sv
// Command decoder for pass-through and bus reset parameter blocks
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Buffer address is a bus address; Short I/O lists offset from base.
// - Transfer length is max byte count, or list element count.
// - Returned block's transfer length becomes actual bytes moved.
// - Words 0xC-0xD are zero, or the summed list entry counts.
// - Standard addressing takes target id from unit bits 2..0.
// - Standard addressing takes logical unit from unit bits 5..3.
// - Unit bit 6 picks primary or secondary bus in both forms.
// - Unit bit 7 selects wide_logical_unit_field bits 13..8, target bits 3..0.
// - Descriptor bytes from word 0x10 go to target unchanged.
// - Group code sizes descriptor at 6, 10 or 12 bytes.
// - Groups 6 and 7 take entry length minus 0x10 words.
// - Controller error code lands in return status bits 7..0.
// - Target status byte lands unchanged in status bits 15..8.
// - Bad target status triggers one queue policy only.
// - Autosense writes sense data over descriptor bytes onward.
// - Bus reset resets bus and terminates its pending commands.
// - Reset returns all active commands on that bus, aborted.
// - Freeze-on-reset option freezes queues hit by the reset.
// - Only code 0x22 runs reset; bus word at 0xE.
// - Reset bus word bit 15 picks channel 0 or 1.
// - Reset success writes 0x0011 and uses error vector.
// - Completion interrupt only when options bit 0 is set.
module scd_core (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host block port
  input wire logic [4:0] hst_addr,
  input wire logic hst_wr,
  input wire logic [15:0] hst_wdata,
  output logic [15:0] hst_rdata,
  input wire logic hst_go,
  input wire logic [7:0] hst_entry_len,
  output logic hst_busy,
  // Target command
  output logic tgt_start,
  output logic [3:0] tgt_id,
  output logic [5:0] tgt_lun,
  output logic tgt_bus,
  output logic tgt_sg,
  output logic tgt_dir,
  output logic [31:0] tgt_addr,
  output logic [31:0] tgt_len,
  output logic [31:0] tgt_sgsum,
  // Descriptor stream
  output logic cdb_valid,
  output logic [7:0] cdb_byte,
  output logic cdb_last,
  input wire logic cdb_ready,
  // Target completion
  input wire logic tgt_done,
  input wire logic [7:0] tgt_status,
  input wire logic [7:0] tgt_err,
  input wire logic [31:0] tgt_count,
  // Queue policy
  input wire logic [1:0] q_policy,
  output logic q_freeze,
  output logic q_abort,
  // Sense stream
  output logic sense_req,
  output logic sense_ready,
  input wire logic sense_valid,
  input wire logic [7:0] sense_byte,
  input wire logic sense_last,
  // Bus reset
  input wire logic freeze_on_rst,
  input wire logic bus_rst_done,
  output logic bus_rst_req,
  output logic bus_rst_chan,
  output logic bus_abort,
  output logic rst_freeze,
  // Completion
  output logic cmp_done,
  output logic cmp_irq,
  output logic [7:0] cmp_vector,
  output logic [2:0] cmp_level
);

  // ==========================================================
  // State
  scd_pkg::scd_state_t state_reg, state_next;
  logic [4:0] ptr_reg, ptr_next;
  logic [5:0] cnt_reg, cnt_next;
  logic half_reg, half_next;
  logic sfull_reg, sfull_next;
  logic [15:0] wbuf_reg, wbuf_next;
  logic [15:0] cmd_reg, cmd_next;
  logic [15:0] opt_reg, opt_next;
  logic [15:0] vec_reg, vec_next;
  logic [2:0] lvl_reg, lvl_next;
  logic [1:0] mtype_reg, mtype_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] len_reg, len_next;
  logic [31:0] sg_reg, sg_next;
  logic [15:0] busw_reg, busw_next;
  logic [15:0] unit_reg, unit_next;
  logic [7:0] byte0_reg, byte0_next;
  logic [7:0] elen_reg, elen_next;
  logic [15:0] stat_reg, stat_next;
  logic [31:0] count_reg, count_next;
  logic busy_next, start_next, valid_next, last_next;
  logic [7:0] byte_next;
  logic freeze_next, abort_next, sreq_next, sready_next;
  logic brq_next, bch_next, bab_next, rfz_next;
  logic done_next, irq_next;
  logic [7:0] vect_next;
  logic [2:0] level_next;
  logic [3:0] id_next;
  logic [5:0] lun_next;
  logic bus_next, sgo_next, dir_next;
  logic [31:0] taddr_next;

  // Memory port, shared: host while idle, engine in its fetch, descriptor, sense and write-back states, host address elsewhere
  logic [4:0] m_addr;
  logic m_we;
  logic [15:0] m_wdata;
  logic [15:0] m_rdata;
  logic [4:0] cap_addr;
  logic [2:0] group;
  logic [7:0] user_words;

  scd_block_ram u_ram (
    .clk(clk),
    .addr(m_addr),
    .we(m_we),
    .wdata(m_wdata),
    .rdata(m_rdata)
  );

  assign hst_rdata = m_rdata;
  assign cap_addr = ptr_reg - 5'h01;
  assign group = byte0_reg[7:5];
  assign user_words = elen_reg - scd_pkg::BLOCK_OVERHEAD;

  // ==========================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    half_next = half_reg;
    sfull_next = sfull_reg;
    wbuf_next = wbuf_reg;
    cmd_next = cmd_reg;
    opt_next = opt_reg;
    vec_next = vec_reg;
    lvl_next = lvl_reg;
    mtype_next = mtype_reg;
    addr_next = addr_reg;
    len_next = len_reg;
    sg_next = sg_reg;
    busw_next = busw_reg;
    unit_next = unit_reg;
    byte0_next = byte0_reg;
    elen_next = elen_reg;
    stat_next = stat_reg;
    count_next = count_reg;
    busy_next = hst_busy;
    start_next = 1'b0;
    valid_next = cdb_valid;
    last_next = cdb_last;
    byte_next = cdb_byte;
    freeze_next = 1'b0;
    abort_next = 1'b0;
    sreq_next = 1'b0;
    sready_next = sense_ready;
    brq_next = 1'b0;
    bch_next = bus_rst_chan;
    bab_next = 1'b0;
    rfz_next = 1'b0;
    done_next = 1'b0;
    irq_next = 1'b0;
    vect_next = cmp_vector;
    level_next = cmp_level;
    id_next = tgt_id;
    lun_next = tgt_lun;
    bus_next = tgt_bus;
    sgo_next = tgt_sg;
    dir_next = tgt_dir;
    taddr_next = tgt_addr;
    m_addr = hst_addr;
    m_we = 1'b0;
    m_wdata = hst_wdata;
    case (state_reg)
      scd_pkg::ST_IDLE: begin
        m_we = hst_wr;
        if (hst_go) begin
          busy_next = 1'b1;
          ptr_next = 5'h00;
          elen_next = hst_entry_len;
          state_next = scd_pkg::ST_FETCH;
        end
      end
      scd_pkg::ST_FETCH: begin
        // Read data trails the address by one cycle
        m_addr = ptr_reg;
        ptr_next = ptr_reg + 5'h01;
        if (ptr_reg != 5'h00) begin
          if (cap_addr == scd_pkg::W_CMD) begin
            cmd_next = m_rdata;
          end else if (cap_addr == scd_pkg::W_OPT) begin
            opt_next = m_rdata;
          end else if (cap_addr == scd_pkg::W_VEC) begin
            vec_next = m_rdata;
          end else if (cap_addr == scd_pkg::W_LVL) begin
            lvl_next = m_rdata[2:0];
          end else if (cap_addr == scd_pkg::W_VTT) begin
            mtype_next = m_rdata[9:8];
          end else if (cap_addr == scd_pkg::W_ADDR_HI) begin
            addr_next[31:16] = m_rdata;
          end else if (cap_addr == scd_pkg::W_ADDR_LO) begin
            addr_next[15:0] = m_rdata;
          end else if (cap_addr == scd_pkg::W_LEN_HI) begin
            len_next[31:16] = m_rdata;
          end else if (cap_addr == scd_pkg::W_LEN_LO) begin
            len_next[15:0] = m_rdata;
          end else if (cap_addr == scd_pkg::W_SG_HI) begin
            sg_next[31:16] = m_rdata;
          end else if (cap_addr == scd_pkg::W_SG_LO) begin
            sg_next[15:0] = m_rdata;
          end else if (cap_addr == scd_pkg::W_BUS) begin
            busw_next = m_rdata;
          end else if (cap_addr == scd_pkg::W_UNIT) begin
            unit_next = m_rdata;
          end else if (cap_addr == scd_pkg::W_CDB) begin
            byte0_next = m_rdata[15:8];
          end
        end
        if (ptr_reg == scd_pkg::FETCH_END) begin
          state_next = scd_pkg::ST_DECODE;
        end
      end
      scd_pkg::ST_DECODE: begin
        count_next = 32'h0000_0000;
        if (cmd_reg == scd_pkg::CMD_RESET) begin
          state_next = scd_pkg::ST_RST_GO;
        end else if (cmd_reg != scd_pkg::CMD_PASS) begin
          stat_next = {8'h00, scd_pkg::ERR_BAD_CMD};
          state_next = scd_pkg::ST_WB_STAT;
        end else begin
          // Known groups ignore the queue entry length
          case (group)
            3'h0: cnt_next = scd_pkg::CDB_LEN_G0;
            3'h1, 3'h2: cnt_next = scd_pkg::CDB_LEN_G12;
            3'h5: cnt_next = scd_pkg::CDB_LEN_G5;
            3'h6, 3'h7: cnt_next = {user_words[4:0], 1'b0};
            default: cnt_next = 6'h00;
          endcase
          if (group == 3'h3 || group == 3'h4) begin
            stat_next = {8'h00, scd_pkg::ERR_BAD_GROUP};
            state_next = scd_pkg::ST_WB_STAT;
          end else if (group[2:1] == 2'h3 &&
                       (elen_reg <= scd_pkg::BLOCK_OVERHEAD ||
                        elen_reg > scd_pkg::BLOCK_MAX_WORDS)) begin
            // User lengths beyond the on-board block are refused
            stat_next = {8'h00, scd_pkg::ERR_BAD_LEN};
            state_next = scd_pkg::ST_WB_STAT;
          end else begin
            start_next = 1'b1;
            if (unit_reg[scd_pkg::UNIT_EXT_BIT]) begin
              id_next = unit_reg[3:0];
              lun_next = unit_reg[13:8];
            end else begin
              id_next = {1'b0, unit_reg[2:0]};
              lun_next = {3'h0, unit_reg[5:3]};
            end
            bus_next = unit_reg[scd_pkg::UNIT_BUS_BIT];
            sgo_next = opt_reg[scd_pkg::OPT_SG_BIT];
            dir_next = opt_reg[scd_pkg::OPT_DIR_BIT];
            if (opt_reg[scd_pkg::OPT_SG_BIT] &&
                mtype_reg == scd_pkg::MT_SHORT_IO) begin
              taddr_next = scd_pkg::SIO_BASE + addr_reg;
            end else begin
              taddr_next = addr_reg;
            end
            ptr_next = scd_pkg::W_CDB;
            state_next = scd_pkg::ST_CDB_RD;
          end
        end
      end
      scd_pkg::ST_CDB_RD: begin
        m_addr = ptr_reg;
        state_next = scd_pkg::ST_CDB_LD;
      end
      scd_pkg::ST_CDB_LD: begin
        wbuf_next = m_rdata;
        valid_next = 1'b1;
        byte_next = m_rdata[15:8];
        last_next = (cnt_reg == 6'h01);
        half_next = 1'b0;
        state_next = scd_pkg::ST_CDB_TX;
      end
      scd_pkg::ST_CDB_TX: begin
        if (cdb_ready) begin
          cnt_next = cnt_reg - 6'h01;
          if (cdb_last) begin
            valid_next = 1'b0;
            last_next = 1'b0;
            state_next = scd_pkg::ST_WAIT;
          end else if (!half_reg) begin
            byte_next = wbuf_reg[7:0];
            half_next = 1'b1;
            last_next = (cnt_reg == 6'h02);
          end else begin
            valid_next = 1'b0;
            ptr_next = ptr_reg + 5'h01;
            state_next = scd_pkg::ST_CDB_RD;
          end
        end
      end
      scd_pkg::ST_WAIT: begin
        if (tgt_done) begin
          stat_next = {tgt_status, tgt_err};
          count_next = tgt_count;
          state_next = scd_pkg::ST_WB_STAT;
          if (tgt_status != 8'h00) begin
            case (scd_pkg::scd_policy_t'(q_policy))
              scd_pkg::POL_FREEZE: freeze_next = 1'b1;
              scd_pkg::POL_ABORT: abort_next = 1'b1;
              scd_pkg::POL_SENSE: begin
                if (tgt_status == scd_pkg::SCSI_CHECK) begin
                  sreq_next = 1'b1;
                  sready_next = 1'b1;
                  ptr_next = scd_pkg::W_CDB;
                  half_next = 1'b0;
                  sfull_next = 1'b0;
                  state_next = scd_pkg::ST_SENSE;
                end
              end
              default: freeze_next = 1'b0;
            endcase
          end
        end
      end
      scd_pkg::ST_SENSE: begin
        // Sense bytes pack high byte first over the descriptor area
        m_addr = ptr_reg;
        m_wdata = half_reg ? {wbuf_reg[15:8], sense_byte} :
                             {sense_byte, 8'h00};
        if (sense_valid) begin
          if (half_reg || sense_last) begin
            m_we = !sfull_reg;
            ptr_next = ptr_reg + 5'h01;
            half_next = 1'b0;
            if (ptr_reg == scd_pkg::W_LAST) begin
              sfull_next = 1'b1;
            end
          end else begin
            wbuf_next = {sense_byte, 8'h00};
            half_next = 1'b1;
          end
          if (sense_last) begin
            sready_next = 1'b0;
            state_next = scd_pkg::ST_WB_STAT;
          end
        end
      end
      scd_pkg::ST_RST_GO: begin
        brq_next = 1'b1;
        bch_next = busw_reg[scd_pkg::RST_BUS_BIT];
        bab_next = 1'b1;
        rfz_next = freeze_on_rst;
        state_next = scd_pkg::ST_RST_WAIT;
      end
      scd_pkg::ST_RST_WAIT: begin
        if (bus_rst_done) begin
          stat_next = scd_pkg::STAT_RESET_OK;
          state_next = scd_pkg::ST_WB_STAT;
        end
      end
      scd_pkg::ST_WB_STAT: begin
        m_addr = scd_pkg::W_STAT;
        m_we = 1'b1;
        m_wdata = stat_reg;
        if (cmd_reg == scd_pkg::CMD_RESET) begin
          state_next = scd_pkg::ST_FINISH;
        end else begin
          state_next = scd_pkg::ST_WB_LEN_HI;
        end
      end
      scd_pkg::ST_WB_LEN_HI: begin
        m_addr = scd_pkg::W_LEN_HI;
        m_we = 1'b1;
        m_wdata = count_reg[31:16];
        state_next = scd_pkg::ST_WB_LEN_LO;
      end
      scd_pkg::ST_WB_LEN_LO: begin
        m_addr = scd_pkg::W_LEN_LO;
        m_we = 1'b1;
        m_wdata = count_reg[15:0];
        state_next = scd_pkg::ST_FINISH;
      end
      scd_pkg::ST_FINISH: begin
        done_next = 1'b1;
        irq_next = opt_reg[scd_pkg::OPT_IRQ_BIT];
        // Any non-zero status, reset success included, uses error vector
        vect_next = (stat_reg != 16'h0000) ? vec_reg[7:0] :
                                             vec_reg[15:8];
        level_next = lvl_reg;
        busy_next = 1'b0;
        state_next = scd_pkg::ST_IDLE;
      end
      default: state_next = scd_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= scd_pkg::ST_IDLE;
      ptr_reg <= 5'h00;
      cnt_reg <= 6'h00;
      half_reg <= 1'b0;
      sfull_reg <= 1'b0;
      wbuf_reg <= 16'h0000;
      cmd_reg <= 16'h0000;
      opt_reg <= 16'h0000;
      vec_reg <= 16'h0000;
      lvl_reg <= 3'h0;
      mtype_reg <= 2'h0;
      addr_reg <= 32'h0000_0000;
      len_reg <= 32'h0000_0000;
      sg_reg <= 32'h0000_0000;
      busw_reg <= 16'h0000;
      unit_reg <= 16'h0000;
      byte0_reg <= 8'h00;
      elen_reg <= 8'h00;
      stat_reg <= 16'h0000;
      count_reg <= 32'h0000_0000;
      hst_busy <= 1'b0;
      tgt_start <= 1'b0;
      tgt_id <= 4'h0;
      tgt_lun <= 6'h00;
      tgt_bus <= 1'b0;
      tgt_sg <= 1'b0;
      tgt_dir <= 1'b0;
      tgt_addr <= 32'h0000_0000;
      tgt_len <= 32'h0000_0000;
      tgt_sgsum <= 32'h0000_0000;
      cdb_valid <= 1'b0;
      cdb_byte <= 8'h00;
      cdb_last <= 1'b0;
      q_freeze <= 1'b0;
      q_abort <= 1'b0;
      sense_req <= 1'b0;
      sense_ready <= 1'b0;
      bus_rst_req <= 1'b0;
      bus_rst_chan <= 1'b0;
      bus_abort <= 1'b0;
      rst_freeze <= 1'b0;
      cmp_done <= 1'b0;
      cmp_irq <= 1'b0;
      cmp_vector <= 8'h00;
      cmp_level <= 3'h0;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      half_reg <= half_next;
      sfull_reg <= sfull_next;
      wbuf_reg <= wbuf_next;
      cmd_reg <= cmd_next;
      opt_reg <= opt_next;
      vec_reg <= vec_next;
      lvl_reg <= lvl_next;
      mtype_reg <= mtype_next;
      addr_reg <= addr_next;
      len_reg <= len_next;
      sg_reg <= sg_next;
      busw_reg <= busw_next;
      unit_reg <= unit_next;
      byte0_reg <= byte0_next;
      elen_reg <= elen_next;
      stat_reg <= stat_next;
      count_reg <= count_next;
      hst_busy <= busy_next;
      tgt_start <= start_next;
      tgt_id <= id_next;
      tgt_lun <= lun_next;
      tgt_bus <= bus_next;
      tgt_sg <= sgo_next;
      tgt_dir <= dir_next;
      tgt_addr <= taddr_next;
      tgt_len <= start_next ? len_reg : tgt_len;
      tgt_sgsum <= start_next ? sg_reg : tgt_sgsum;
      cdb_valid <= valid_next;
      cdb_byte <= byte_next;
      cdb_last <= last_next;
      q_freeze <= freeze_next;
      q_abort <= abort_next;
      sense_req <= sreq_next;
      sense_ready <= sready_next;
      bus_rst_req <= brq_next;
      bus_rst_chan <= bch_next;
      bus_abort <= bab_next;
      rst_freeze <= rfz_next;
      cmp_done <= done_next;
      cmp_irq <= irq_next;
      cmp_vector <= vect_next;
      cmp_level <= level_next;
    end
  end

endmodule

`default_nettype wire

// >>> scd_core_properties.sv
// Port checker for the command decoder
`timescale 1ns/10ps
`default_nettype none
module scd_core_properties (
  // Clock, reset and host
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] hst_addr,
  input wire logic hst_wr,
  input wire logic [15:0] hst_wdata,
  input wire logic hst_busy,
  // Target side
  input wire logic tgt_start,
  input wire logic [3:0] tgt_id,
  input wire logic [5:0] tgt_lun,
  input wire logic tgt_bus,
  input wire logic cdb_valid,
  input wire logic [7:0] cdb_byte,
  input wire logic cdb_ready,
  input wire logic [1:0] q_policy,
  input wire logic q_freeze,
  input wire logic q_abort,
  // Bus reset and completion
  input wire logic freeze_on_rst,
  input wire logic bus_rst_done,
  input wire logic bus_rst_req,
  input wire logic bus_rst_chan,
  input wire logic bus_abort,
  input wire logic rst_freeze,
  input wire logic cmp_done,
  input wire logic cmp_irq
);
  // ==========
  // Shadow of host words, writes only land while idle
  logic [15:0] cmd_reg, cmd_next, unit_reg, unit_next;
  logic bus_reg, bus_next, opt_reg, opt_next;
  always_comb begin
    {cmd_next, unit_next} = {cmd_reg, unit_reg};
    {bus_next, opt_next} = {bus_reg, opt_reg};
    if (hst_wr && !hst_busy)
      case (hst_addr)
        scd_pkg::W_CMD: cmd_next = hst_wdata;
        scd_pkg::W_UNIT: unit_next = hst_wdata;
        scd_pkg::W_BUS: bus_next = hst_wdata[15];
        scd_pkg::W_OPT: opt_next = hst_wdata[0];
        default: ;
      endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      {cmd_reg, unit_reg, bus_reg, opt_reg} <= 34'h0;
    else
      {cmd_reg, unit_reg, bus_reg, opt_reg} <=
        {cmd_next, unit_next, bus_next, opt_next};
  end
  // ==========
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence std_start;
    tgt_start && !unit_reg[7];
  endsequence
  sequence rst_issued;
    bus_rst_req ##[1:40] bus_rst_done;
  endsequence
  std_target_a: assert property (std_start |->
    tgt_id == {1'h0, unit_reg[2:0]} && tgt_lun == {3'h0, unit_reg[5:3]})
    else $error("std decode");
  wide_target_a: assert property (tgt_start && unit_reg[7] |->
    tgt_id == unit_reg[3:0] && tgt_lun == unit_reg[13:8])
    else $error("ext decode");
  bus_select_a: assert property (
    tgt_start |-> tgt_bus == unit_reg[6])
    else $error("bus select");
  cdb_hold_a: assert property (
    cdb_valid && !cdb_ready |=> cdb_valid && $stable(cdb_byte))
    else $error("cdb not held");
  one_policy_a: assert property (
    q_freeze || q_abort |-> q_policy == {q_abort, q_freeze})
    else $error("policy mismatch");
  reset_pulses_a: assert property (bus_rst_req |->
    bus_abort && bus_rst_chan == bus_reg && rst_freeze == freeze_on_rst)
    else $error("reset effects");
  reset_done_a: assert property (rst_issued |-> ##3 cmp_done)
    else $error("reset done late");
  irq_gate_a: assert property (cmp_irq == (cmp_done && opt_reg))
    else $error("irq gating");
  code_gate_a: assert property (
    (bus_rst_req |-> cmd_reg == scd_pkg::CMD_RESET) and
    (tgt_start |-> cmd_reg == scd_pkg::CMD_PASS))
    else $error("wrong code");
endmodule
bind scd_core scd_core_properties props_u (.*);
`default_nettype wire

// >>> scd_target_model.sv
// Far-side model: target accepting descriptors and bus reset responder
`timescale 1ns/10ps
`default_nettype none
module scd_target_model (
  // Clock and stream
  input wire logic clk,
  input wire logic cdb_valid,
  input wire logic [7:0] cdb_byte,
  input wire logic cdb_last,
  output logic cdb_ready,
  // Command and reset
  input wire logic tgt_start,
  output logic tgt_done,
  input wire logic bus_rst_req,
  output logic bus_rst_done,
  // Observations
  output int nbytes,
  output logic [7:0] first_byte
);
  int ph = 0;
  int wt = 0;
  int rw = 0;
  initial begin
    {cdb_ready, tgt_done, bus_rst_done} = 3'h0;
    nbytes = 0;
  end
  always @(posedge clk) begin
    if (tgt_start)
      nbytes = 0;
    if (cdb_valid && cdb_ready) begin
      if (nbytes == 0)
        first_byte = cdb_byte;
      nbytes++;
      if (cdb_last)
        wt = 4;
    end
    if (bus_rst_req)
      rw = 6;
  end
  // Ready two cycles on, two off: both prompt and stalled accepts
  always @(negedge clk) begin
    ph++;
    cdb_ready <= ph[1];
    tgt_done <= (wt == 1);
    bus_rst_done <= (rw == 1);
    if (wt > 0)
      wt--;
    if (rw > 0)
      rw--;
  end
endmodule
`default_nettype wire

// >>> tb_scd_core.sv
// Self-checking testbench for the command decoder
`timescale 1ns/10ps
`default_nettype none
module tb_scd_core;
  // ==========
  // Signals
  logic clk = 0, sys_rst = 1, hst_wr = 0, hst_go = 0, freeze_on_rst = 1;
  logic tgt_done, cdb_ready, bus_rst_done, hst_busy, tgt_start, tgt_bus;
  logic tgt_sg, tgt_dir, cdb_valid, cdb_last, q_freeze, q_abort, sense_req;
  logic sense_ready, bus_rst_req, bus_rst_chan, bus_abort, rst_freeze;
  logic cmp_done, cmp_irq, irq, frz;
  logic [4:0] hst_addr = 5'h00;
  logic [15:0] hst_wdata = 16'h0000, hst_rdata, opt = 16'h0001;
  logic [7:0] hst_entry_len = 8'h00, tgt_status = 8'h00, tgt_err = 8'h00;
  logic [7:0] cdb_byte, cmp_vector, first;
  logic [3:0] tgt_id;
  logic [5:0] tgt_lun;
  logic [2:0] cmp_level;
  logic [1:0] q_policy = 2'h0;
  logic [31:0] tgt_addr, tgt_len, tgt_sgsum, tgt_count = 32'h0001_2345;
  int nb, fails = 0, samples_checked = 0;
  always #25 clk = ~clk;
  scd_core dut_u (.*, .sense_valid(1'h0), .sense_byte(8'h00),
    .sense_last(1'h0));
  scd_target_model tgt_u (.*, .nbytes(nb), .first_byte(first));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    {hst_addr, hst_wdata, hst_wr} = {a, d, 1'h1};
    @(negedge clk);
    hst_wr = 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk);
    hst_addr = a;
    @(negedge clk);
    chk(hst_rdata, e);
  endtask
  task automatic run(input logic [15:0] cmd, unit, w10, input logic [7:0] el);
    int n;
    n = 0;
    wr(5'h00, cmd);
    wr(5'h0f, unit);
    wr(5'h10, w10);
    wr(5'h01, opt);
    {hst_entry_len, hst_go, frz} = {el, 1'h1, 1'h0};
    @(negedge clk);
    hst_go = 1'h0;
    do begin
      @(negedge clk);
      n++;
      frz |= q_freeze;
    end while (cmp_done !== 1'h1 && n < 500);
    irq = cmp_irq;
    if (n >= 500)
      fails++;
  endtask
  task automatic pt(input logic [15:0] unit, w10, input logic [7:0] el,
      input int nbx, input logic [3:0] id, input logic [5:0] lun);
    run(scd_pkg::CMD_PASS, unit, w10, el);
    chk(nb, nbx);
    chk(first, w10[15:8]);
    chk(tgt_id, id);
    chk(tgt_lun, lun);
    chk(tgt_bus, unit[6]);
    chk(irq, opt[0]);
    rd(5'h02, {tgt_status, tgt_err});
    rd(5'h0b, tgt_count[15:0]);
    rd(5'h0a, tgt_count[31:16]);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // Tests; watchdog at 20000 clock cycles, far past their span
  initial begin
    #(50 * 20000);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    wr(5'h04, 16'ha55a);
    wr(5'h08, 16'h1234);
    wr(5'h09, 16'h5678);
    wr(5'h0a, 16'h0000);
    wr(5'h0b, 16'h0200);
    wr(5'h0c, 16'h0000);
    wr(5'h0d, 16'h0000);
    // Known descriptor bytes beyond byte 1, none left unknown
    for (int i = 17; i < 22; i++) wr(5'(i), 16'h0000);
    pt(16'h006d, 16'ha011, 8'h30, 12, 4'h5, 6'h05);
    chk(tgt_addr, 32'h1234_5678);
    chk(tgt_len, 32'h0000_0200);
    chk(tgt_sgsum, 32'h0000_0000);
    opt = 16'h0000;
    pt(16'h0007, 16'h2800, 8'h00, 10, 4'h7, 6'h00);
    pt(16'h0000, 16'h4800, 8'h00, 10, 4'h0, 6'h00);
    {tgt_status, q_policy} = {8'h02, 2'h1};
    pt(16'h2a8b, 16'h0811, 8'h00, 6, 4'hb, 6'h2a);
    chk(frz, 1'h1);
    {tgt_status, q_policy} = {8'h00, 2'h0};
    pt(16'h0000, 16'hc000, 8'h14, 8, 4'h0, 6'h00);
    pt(16'h0000, 16'he000, 8'h11, 2, 4'h0, 6'h00);
    run(scd_pkg::CMD_PASS, 16'h0000, 16'h6000, 8'h00);
    chk(nb, 2);
    rd(5'h02, 16'h0002);
    run(16'h0021, 16'h0000, 16'h2800, 8'h00);
    rd(5'h02, 16'h0001);
    wr(5'h0e, 16'h8000);
    run(scd_pkg::CMD_RESET, 16'h0000, 16'h0000, 8'h00);
    rd(5'h02, 16'h0011);
    chk(bus_rst_chan, 1'h1);
    chk(cmp_vector, 8'h5a);
    report_and_stop();
  end
endmodule
`default_nettype wire
